// File: logic/host_read_path.sv
// Operation
// - no valid read data before initialization done
// - reads ignored outside full power state
// - read tail ignored when full power returns
// - same lane twice unguarded; reads only counted
// - per path read lane counter, trailing edge
// - last lane performs exactly one internal read; fifo path pops instead
// - lane counters cleared outside full power
// - live bits frozen at read cycle start
// - first lane locks, last lane unlocks register
// - locks released outside full power
// - pops and side effects at read end
// - events during hold deferred, not lost
// - pollable registers: single lane, no advance
// - endianness bit per pair and fifo
// - bytes reordered by endianness and address
// - direct address range reads the fifo
// - fifo path uses fifo endianness bit
// - strobe polarities and strobe style configurable
// - byte mode drives only low eight lines
// - writes ignored until a read follows
// - read cycle from select and read strobes
`timescale 1ns/1ps
`default_nettype none
module host_read_path (
  input wire logic clock,
  input wire logic rstn,
  input wire logic cs_pin,
  input wire logic rd_pin,
  input wire logic wr_pin,
  input wire logic [host_port_pkg::ADDR_W-1:0] addr_pin,
  input wire logic cs_active_high,
  input wire logic rd_active_high,
  input wire logic wr_active_high,
  input wire logic dir_enable_mode,
  input wire logic byte_mode,
  input wire logic [3:0] endian,
  input wire logic full_power_state,
  input wire logic init_done,
  input wire logic [host_port_pkg::INDEX_W-1:0] index_reg0,
  input wire logic [host_port_pkg::INDEX_W-1:0] index_reg1,
  input wire logic [host_port_pkg::INDEX_W-1:0] index_reg2,
  input wire logic [host_port_pkg::WORD_W-1:0] reg_data,
  input wire logic reg_pollable,
  input wire logic [host_port_pkg::WORD_W-1:0] fifo_data,
  input wire logic hw_event,
  output logic [host_port_pkg::DATA_W-1:0] data_out,
  output logic data_oe_lo,
  output logic data_oe_hi,
  output logic [host_port_pkg::INDEX_W-1:0] int_addr,
  output logic int_read,
  output logic fifo_pop,
  output logic regs_hold,
  output logic writes_enabled,
  output logic event_status
);

  // ==========================================================
  // pin synchronisers
  logic [host_port_pkg::SYNC_STAGES-1:0] cs_sync;
  logic [host_port_pkg::SYNC_STAGES-1:0] rd_sync;
  logic [host_port_pkg::SYNC_STAGES-1:0] wr_sync;
  logic [host_port_pkg::ADDR_W-1:0] addr_meta;
  logic [host_port_pkg::ADDR_W-1:0] addr_s;
  logic [host_port_pkg::SYNC_STAGES-1:0] cs_pol;
  logic [host_port_pkg::SYNC_STAGES-1:0] rd_pol;
  logic [host_port_pkg::SYNC_STAGES-1:0] wr_pol;
  logic [host_port_pkg::SYNC_STAGES-1:0] dir_mode;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cs_sync <= '0;
      rd_sync <= '0;
      wr_sync <= '0;
      addr_meta <= '0;
      addr_s <= '0;
      cs_pol <= '0;
      rd_pol <= '0;
      wr_pol <= '0;
      dir_mode <= '0;
    end else begin
      cs_sync <= {cs_sync[0], cs_pin};
      rd_sync <= {rd_sync[0], rd_pin};
      wr_sync <= {wr_sync[0], wr_pin};
      addr_meta <= addr_pin;
      addr_s <= addr_meta;
      // settings travel beside the pins, so a polarity change never looks like a strobe
      cs_pol <= {cs_pol[0], cs_active_high};
      rd_pol <= {rd_pol[0], rd_active_high};
      wr_pol <= {wr_pol[0], wr_active_high};
      dir_mode <= {dir_mode[0], dir_enable_mode};
    end
  end

  // ==========================================================
  // read cycle detection
  logic cs_act;
  logic rd_act;
  logic wr_act;
  logic read_cycle;
  logic cycle_prev;
  logic lead;
  logic trail;

  assign cs_act = (cs_sync[1] == cs_pol[1]);
  assign rd_act = (rd_sync[1] == rd_pol[1]);
  assign wr_act = (wr_sync[1] == wr_pol[1]);
  // in direction mode the read pin carries direction, the write pin the enable
  assign read_cycle = cs_act & (dir_mode[1] ? (wr_act & rd_act) : rd_act);
  assign lead = read_cycle & ~cycle_prev;
  assign trail = ~read_cycle & cycle_prev;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      // the flops reset to a level that may read as active: no false lead after reset
      cycle_prev <= 1'b1;
    end else begin
      cycle_prev <= read_cycle;
    end
  end

  // ==========================================================
  // cycle state
  host_port_pkg::read_state_e state;
  host_port_pkg::read_state_e next_state;
  logic [2:0] cur_sel;
  logic [1:0] cur_lane;
  logic cur_poll;
  logic [1:0] count [host_port_pkg::PATHS];
  logic [3:0] lock;
  logic [host_port_pkg::WORD_W-1:0] word [host_port_pkg::PATHS];
  logic [1:0] cur_path;
  logic [1:0] cur_count;
  logic [1:0] last_count;
  logic counted;
  logic poll_now;
  logic advance;
  logic complete;
  logic hold_now;

  assign cur_path = cur_sel[2:1];
  assign cur_count = count[cur_path];
  assign counted = (cur_sel[0] & (cur_sel != host_port_pkg::SEL_CONFIG))
    | (cur_sel == host_port_pkg::SEL_FIFO);
  assign poll_now = reg_pollable & (cur_sel != host_port_pkg::SEL_FIFO);
  assign last_count = byte_mode ? host_port_pkg::LANE_LAST_8 : host_port_pkg::LANE_LAST_16;
  // the lane itself is never checked: a repeated lane still counts
  assign advance = (state == host_port_pkg::ACTIVE) & trail & full_power_state
    & counted & ~cur_poll;
  assign complete = advance & (cur_count == last_count);
  assign hold_now = (state != host_port_pkg::IDLE) | (|lock);

  always_comb begin
    next_state = state;
    case (state)
      host_port_pkg::IDLE: begin
        if (lead && full_power_state) begin
          next_state = host_port_pkg::CAPTURE;
        end
      end
      host_port_pkg::CAPTURE: begin
        next_state = host_port_pkg::ACTIVE;
      end
      host_port_pkg::ACTIVE: begin
        if (trail) begin
          next_state = host_port_pkg::IDLE;
        end
      end
      default: begin
        next_state = host_port_pkg::IDLE;
      end
    endcase
    // a cycle that began in low power never leaves idle, so its tail is dropped
    if (!full_power_state) begin
      next_state = host_port_pkg::IDLE;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state <= host_port_pkg::IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cur_sel <= host_port_pkg::SEL_INDEX0;
      cur_lane <= host_port_pkg::LANE_FIRST;
      cur_poll <= 1'b0;
    end else if (state == host_port_pkg::IDLE && lead) begin
      cur_sel <= addr_s[4:2];
      cur_lane <= addr_s[1:0];
    end else if (state == host_port_pkg::CAPTURE) begin
      cur_poll <= poll_now;
    end
  end

  // ==========================================================
  // internal address, follows the addressed pair while idle
  logic [host_port_pkg::INDEX_W-1:0] next_int_addr;

  always_comb begin
    next_int_addr = int_addr;
    if (state == host_port_pkg::IDLE) begin
      case (addr_s[4:3])
        2'h0: next_int_addr = index_reg0;
        2'h1: next_int_addr = index_reg1;
        2'h2: next_int_addr = index_reg2;
        default: next_int_addr = int_addr;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      int_addr <= '0;
    end else begin
      int_addr <= next_int_addr;
    end
  end

  // ==========================================================
  // lane counters and locks
  logic first_lane;
  assign first_lane = (state == host_port_pkg::CAPTURE) & counted & ~poll_now
    & (cur_count == host_port_pkg::LANE_FIRST) & full_power_state;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < host_port_pkg::PATHS; i++) begin
        count[i] <= host_port_pkg::LANE_FIRST;
      end
    end else if (!full_power_state) begin
      for (int i = 0; i < host_port_pkg::PATHS; i++) begin
        count[i] <= host_port_pkg::LANE_FIRST;
      end
    end else if (complete) begin
      count[cur_path] <= host_port_pkg::LANE_FIRST;
    end else if (advance) begin
      count[cur_path] <= cur_count + host_port_pkg::LANE_STEP;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      lock <= '0;
    end else if (!full_power_state) begin
      lock <= '0;
    end else if (first_lane) begin
      lock[cur_path] <= 1'b1;
    end else if (complete) begin
      lock[cur_path] <= 1'b0;
    end
  end

  // ==========================================================
  // snapshot and byte ordering
  logic [host_port_pkg::WORD_W-1:0] fresh;
  logic [host_port_pkg::WORD_W-1:0] shown;
  logic [host_port_pkg::WORD_W-1:0] ordered;
  logic [host_port_pkg::DATA_W-1:0] lane_data;
  logic use_fresh;
  logic endian_cur;

  always_comb begin
    case (cur_sel)
      host_port_pkg::SEL_INDEX0: fresh = {16'h0000, index_reg0};
      host_port_pkg::SEL_INDEX1: fresh = {16'h0000, index_reg1};
      host_port_pkg::SEL_INDEX2: fresh = {16'h0000, index_reg2};
      host_port_pkg::SEL_FIFO: fresh = fifo_data;
      host_port_pkg::SEL_CONFIG: fresh = {4{4'h0, endian}};
      default: begin
        if (int_addr == host_port_pkg::EVENT_REG_INDEX) begin
          fresh = {31'h0, event_status};
        end else begin
          fresh = reg_data;
        end
      end
    endcase
  end

  // later lanes of a locked word come from the stored copy, never live data
  assign use_fresh = ~(counted & ~poll_now & (cur_count != host_port_pkg::LANE_FIRST));
  assign shown = use_fresh ? fresh : word[cur_path];
  assign endian_cur = (cur_sel == host_port_pkg::SEL_FIFO) ? endian[host_port_pkg::FIFO_ENDIAN_BIT]
    : (cur_sel == host_port_pkg::SEL_CONFIG) ? endian[host_port_pkg::CONFIG_ENDIAN_BIT]
    : endian[cur_path];
  assign ordered = endian_cur ? {shown[7:0], shown[15:8], shown[23:16], shown[31:24]}
    : shown;
  assign lane_data = byte_mode ? {8'h00, ordered[{cur_lane, 3'b000} +: 8]}
    : ordered[{cur_lane[1], 4'b0000} +: 16];

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < host_port_pkg::PATHS; i++) begin
        word[i] <= '0;
      end
    end else if (state == host_port_pkg::CAPTURE && counted && use_fresh) begin
      word[cur_path] <= fresh;
    end
  end

  // ==========================================================
  // data lanes
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      data_out <= '0;
      data_oe_lo <= 1'b0;
      data_oe_hi <= 1'b0;
    end else if (next_state != host_port_pkg::ACTIVE) begin
      data_oe_lo <= 1'b0;
      data_oe_hi <= 1'b0;
    end else if (state == host_port_pkg::CAPTURE) begin
      // before initialization the lanes carry zero rather than stale data
      data_out <= init_done ? lane_data : '0;
      data_oe_lo <= 1'b1;
      data_oe_hi <= ~byte_mode;
    end
  end

  // ==========================================================
  // end of read effects
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      int_read <= 1'b0;
      fifo_pop <= 1'b0;
      regs_hold <= 1'b0;
      writes_enabled <= 1'b0;
    end else begin
      int_read <= complete & (cur_path != host_port_pkg::PATH_FIFO);
      fifo_pop <= complete & (cur_path == host_port_pkg::PATH_FIFO);
      regs_hold <= hold_now;
      if (!full_power_state) begin
        writes_enabled <= 1'b0;
      end else if (state == host_port_pkg::ACTIVE && trail) begin
        writes_enabled <= 1'b1;
      end
    end
  end

  // ==========================================================
  // change-on-read event flag
  logic pending;
  logic event_clear;
  assign event_clear = int_read & (int_addr == host_port_pkg::EVENT_REG_INDEX);

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pending <= 1'b0;
      event_status <= 1'b0;
    end else begin
      if (hw_event && hold_now) begin
        pending <= 1'b1;
      end else if (!hold_now) begin
        pending <= 1'b0;
      end
      // a set on the clearing cycle wins
      event_status <= (event_status & ~event_clear)
        | (~hold_now & (hw_event | pending));
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  chk_low_power_ignore: assert property (
    (state == host_port_pkg::IDLE && lead && !full_power_state) |=> state == host_port_pkg::IDLE
  ) else $error("read started outside full power");

  chk_counter_clear: assert property (
    !full_power_state |=> (count[0] == 2'h0 && count[1] == 2'h0 && count[2] == 2'h0
      && count[3] == 2'h0)
  ) else $error("lane counter kept in low power");

  chk_lock_release: assert property (
    !full_power_state |=> lock == 4'h0
  ) else $error("lock kept in low power");

  chk_count_step: assert property (
    (advance && !complete) |=> count[$past(cur_path)] == $past(cur_count) + 2'h1
  ) else $error("lane counter did not step");

  chk_lock_first: assert property (
    first_lane |=> lock[$past(cur_path)] ##0 regs_hold
  ) else $error("first lane did not lock");

  chk_single_read: assert property (
    complete && cur_path != host_port_pkg::PATH_FIFO |=> int_read ##1 !int_read
  ) else $error("internal read not single");

  chk_pop_at_end: assert property (
    fifo_pop |-> $past(state == host_port_pkg::ACTIVE && trail && cur_path == 2'h3)
  ) else $error("fifo pop away from read end");

  chk_byte_lanes: assert property (
    (state == host_port_pkg::CAPTURE && byte_mode && full_power_state && read_cycle)
      |=> data_oe_lo && !data_oe_hi
  ) else $error("upper lanes driven in byte mode");

  chk_data_stable: assert property (
    data_oe_lo && $past(data_oe_lo) |-> $stable(data_out)
  ) else $error("read data moved during cycle");

  chk_event_kept: assert property (
    (hw_event && hold_now) |=> pending || event_status
  ) else $error("held event lost");

  chk_writes_gate: assert property (
    $rose(writes_enabled) |-> $past(state == host_port_pkg::ACTIVE && trail)
  ) else $error("writes enabled without read");

  chk_init_zero: assert property (
    (state == host_port_pkg::CAPTURE && !init_done && next_state == host_port_pkg::ACTIVE)
      |=> data_out == 16'h0000
  ) else $error("data before init not zero");

  cov_word_done: cover property (complete && byte_mode);
  cov_fifo_pop: cover property (fifo_pop);
  cov_deferred: cover property (pending ##1 event_status);
  cov_power_drop: cover property ((state == host_port_pkg::ACTIVE) ##1 !full_power_state);

endmodule
`default_nettype wire

// File: pkg/host_port_pkg.sv
`default_nettype none
package host_port_pkg;

  // ==========================================================
  // widths
  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;
  localparam int WORD_W = 32;
  localparam int INDEX_W = 16;
  localparam int PATHS = 4;
  localparam int SYNC_STAGES = 2;

  // ==========================================================
  // address map, host address bits [4:2]
  localparam logic [2:0] SEL_INDEX0 = 3'h0;
  localparam logic [2:0] SEL_DATA0 = 3'h1;
  localparam logic [2:0] SEL_INDEX1 = 3'h2;
  localparam logic [2:0] SEL_DATA1 = 3'h3;
  localparam logic [2:0] SEL_INDEX2 = 3'h4;
  localparam logic [2:0] SEL_DATA2 = 3'h5;
  localparam logic [2:0] SEL_FIFO = 3'h6;
  localparam logic [2:0] SEL_CONFIG = 3'h7;
  localparam logic [1:0] PATH_FIFO = 2'h3;
  localparam int FIFO_ENDIAN_BIT = 3;
  localparam int CONFIG_ENDIAN_BIT = 0;

  // ==========================================================
  // lane counting
  localparam logic [1:0] LANE_FIRST = 2'h0;
  localparam logic [1:0] LANE_LAST_8 = 2'h3;
  localparam logic [1:0] LANE_LAST_16 = 2'h1;
  localparam logic [1:0] LANE_STEP = 2'h1;

  // ==========================================================
  // change-on-read event flag, internal register index
  localparam logic [INDEX_W-1:0] EVENT_REG_INDEX = 16'h0040;

  typedef enum logic [1:0] {
    IDLE,
    CAPTURE,
    ACTIVE
  } read_state_e;

endpackage
`default_nettype wire

// File: tb/host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// host processor model: select, strobes and address at set polarity
module host_model (
  input wire logic clock,
  input wire logic cs_active_high,
  input wire logic rd_active_high,
  input wire logic wr_active_high,
  input wire logic dir_enable_mode,
  input wire logic [15:0] data_out,
  input wire logic data_oe_lo,
  input wire logic data_oe_hi,
  input wire logic regs_hold,
  input wire logic [15:0] int_addr,
  output logic cs_pin,
  output logic rd_pin,
  output logic wr_pin,
  output logic [4:0] addr_pin
);
  logic act = 1'b0;
  logic [4:0] a = 5'h00;
  // read cycle is select plus read strobe, or enable with direction at read
  assign cs_pin = act ^ ~cs_active_high;
  assign rd_pin = dir_enable_mode ? rd_active_high : (act ^ ~rd_active_high);
  assign wr_pin = dir_enable_mode ? (act ^ ~wr_active_high) : ~wr_active_high;
  // released address is inverted so a stale sample cannot match by luck
  assign addr_pin = act ? a : ~a;

  // strobe held 8 clocks, idle 6: well above what the synchronizer needs
  task automatic read_lane(input logic [4:0] addr, output logic [15:0] d, output logic lo,
      output logic hi, output logic hold, output logic [15:0] ia);
    @(negedge clock);
    a = addr;
    act = 1'b1;
    repeat (8) @(negedge clock);
    d = data_out;
    lo = data_oe_lo;
    hi = data_oe_hi;
    hold = regs_hold;
    ia = int_addr;
    act = 1'b0;
    repeat (6) @(negedge clock);
  endtask
endmodule
`default_nettype wire

// File: tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clock, rstn, cs_pin, rd_pin, wr_pin, cs_active_high, rd_active_high, wr_active_high;
  logic dir_enable_mode, byte_mode, full_power_state, init_done, reg_pollable, hw_event;
  logic data_oe_lo, data_oe_hi, int_read, fifo_pop, regs_hold, writes_enabled, event_status;
  logic [host_port_pkg::ADDR_W-1:0] addr_pin;
  logic [3:0] endian;
  logic [15:0] index_reg0, index_reg1, index_reg2, data_out, int_addr, d, ia;
  logic [31:0] reg_data, fifo_data, w;
  logic lo, hi, hold;
  int fail_count = 0;
  int comparisons = 0;
  int n_rd = 0;
  int n_pop = 0;
  int t0, k;

  host_read_path i_host_read_path (.clock(clock), .rstn(rstn), .cs_pin(cs_pin), .rd_pin(rd_pin),
    .wr_pin(wr_pin), .addr_pin(addr_pin), .cs_active_high(cs_active_high),
    .rd_active_high(rd_active_high), .wr_active_high(wr_active_high),
    .dir_enable_mode(dir_enable_mode), .byte_mode(byte_mode), .endian(endian),
    .full_power_state(full_power_state), .init_done(init_done), .index_reg0(index_reg0),
    .index_reg1(index_reg1), .index_reg2(index_reg2), .reg_data(reg_data),
    .reg_pollable(reg_pollable), .fifo_data(fifo_data), .hw_event(hw_event),
    .data_out(data_out), .data_oe_lo(data_oe_lo), .data_oe_hi(data_oe_hi),
    .int_addr(int_addr), .int_read(int_read), .fifo_pop(fifo_pop), .regs_hold(regs_hold),
    .writes_enabled(writes_enabled), .event_status(event_status));
  host_model i_host_model (.clock(clock), .cs_active_high(cs_active_high),
    .rd_active_high(rd_active_high), .wr_active_high(wr_active_high),
    .dir_enable_mode(dir_enable_mode), .data_out(data_out), .data_oe_lo(data_oe_lo),
    .data_oe_hi(data_oe_hi), .regs_hold(regs_hold), .int_addr(int_addr), .cs_pin(cs_pin),
    .rd_pin(rd_pin), .wr_pin(wr_pin), .addr_pin(addr_pin));

  // ==========================================================
  // clock, pulse counters, watchdog
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  always @(posedge clock) begin
    if (int_read === 1'b1) n_rd++;
    if (fifo_pop === 1'b1) n_pop++;
  end
  initial begin
    repeat (30000) @(posedge clock);
    fail_count++;
    complete_run();
  end

  // ==========================================================
  // helpers
  function automatic logic [15:0] lane_exp(logic [31:0] v, logic big, logic bm, logic [1:0] a);
    logic [31:0] r;
    r = big ? {v[7:0], v[15:8], v[23:16], v[31:24]} : v;
    if (bm) return {8'h00, r[8*a +: 8]};
    return a[1] ? r[31:16] : r[15:0];
  endfunction
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", name, exp, got);
      fail_count++;
    end
  endtask
  task automatic rd(input logic [4:0] a);
    i_host_model.read_lane(a, d, lo, hi, hold, ia);
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // ==========================================================
  // one whole word through a random path, lanes in shuffled order
  task automatic word_test();
    int path, n, j, r0, p0;
    logic [1:0] perm [4];
    logic [1:0] ln;
    logic [2:0] sel;
    logic [15:0] idx;
    logic big;
    path = $urandom_range(3);
    {byte_mode, cs_active_high, rd_active_high, wr_active_high} = 4'($urandom);
    dir_enable_mode = 1'($urandom);
    endian = 4'($urandom);
    // top bit set keeps random indices away from the event flag register
    index_reg0 = 16'($urandom) | 16'h8000;
    index_reg1 = 16'($urandom) | 16'h8000;
    index_reg2 = 16'($urandom) | 16'h8000;
    w = $urandom;
    reg_data = (path == 3) ? $urandom : w;
    fifo_data = (path == 3) ? w : $urandom;
    sel = (path == 3) ? host_port_pkg::SEL_FIFO : 3'(2 * path + 1);
    big = endian[(path == 3) ? host_port_pkg::FIFO_ENDIAN_BIT : path];
    idx = (path == 0) ? index_reg0 : (path == 1) ? index_reg1 : index_reg2;
    n = byte_mode ? 4 : 2;
    for (j = 0; j < 4; j++) perm[j] = 2'(j);
    for (j = n - 1; j > 0; j--) begin
      k = $urandom_range(j);
      ln = perm[j];
      perm[j] = perm[k];
      perm[k] = ln;
    end
    r0 = n_rd;
    p0 = n_pop;
    for (j = 0; j < n; j++) begin
      ln = byte_mode ? perm[j] : {perm[j][0], 1'b0};
      rd({sel, ln});
      // live source moves on; later lanes must still show the first snapshot
      reg_data = $urandom;
      fifo_data = $urandom;
      check("lane data", lane_exp(w, big, byte_mode, ln), byte_mode ? d & 16'h00FF : d);
      check("data enables", {1'b1, ~byte_mode}, {lo, hi});
      if (path != 3) check("internal index", idx, ia);
      check("hold in cycle", 1, hold);
      check("internal reads", (j == n - 1 && path != 3), n_rd - r0);
      check("fifo pops", (j == n - 1 && path == 3), n_pop - p0);
      check("lock", (j != n - 1), regs_hold);
    end
  endtask

  // ==========================================================
  // main sequence
  initial begin
    w = $urandom(26);
    {rstn, cs_active_high, rd_active_high, wr_active_high, dir_enable_mode, byte_mode} = 6'h00;
    {init_done, reg_pollable, hw_event} = 3'h0;
    full_power_state = 1'b1;
    endian = 4'h0;
    {index_reg0, index_reg1, index_reg2} = 48'h0;
    reg_data = 32'hA5C3_5A3C;
    fifo_data = 32'h0;
    repeat (16) @(posedge clock);
    @(negedge clock) rstn = 1'b1;
    repeat (3) @(negedge clock);
    check("writes after reset", 0, writes_enabled);
    reg_pollable = 1'b1;
    repeat (2) begin
      rd({host_port_pkg::SEL_DATA1, 2'h0});
      check("data before init", 0, d);
    end
    init_done = 1'b1;
    rd({host_port_pkg::SEL_INDEX0, 2'h0});
    endian = 4'h5;
    rd({host_port_pkg::SEL_CONFIG, 2'h0});
    check("config", {8'h05, 8'h05}, d);
    check("writes after read", 1, writes_enabled);
    repeat (3) begin
      rd({host_port_pkg::SEL_DATA1, 2'h2});
      check("poll data", lane_exp(reg_data, 1'b0, 1'b0, 2'h2), d);
    end
    check("poll no read", 0, n_rd);
    check("poll no lock", 0, regs_hold);
    reg_pollable = 1'b0;
    repeat (40) word_test();
    // refused reads and power return in mid-cycle
    full_power_state = 1'b0;
    t0 = n_rd;
    rd({host_port_pkg::SEL_DATA0, 2'h0});
    check("off enable", 0, lo);
    check("off writes", 0, writes_enabled);
    fork
      rd({host_port_pkg::SEL_DATA0, 2'h0});
      begin
        repeat (4) @(negedge clock);
        full_power_state = 1'b1;
      end
    join
    check("tail enable", 0, lo);
    check("tail read", t0, n_rd);
    check("tail hold", 0, regs_hold);
    // partial byte word, then power drop clears count and lock
    {byte_mode, dir_enable_mode, endian} = 6'h20;
    w = $urandom;
    reg_data = w;
    rd({host_port_pkg::SEL_DATA0, 2'h1});
    check("partial lock", 1, regs_hold);
    full_power_state = 1'b0;
    repeat (4) @(negedge clock);
    check("unlock on drop", 0, regs_hold);
    full_power_state = 1'b1;
    check("writes gated", 0, writes_enabled);
    for (k = 0; k < 4; k++) begin
      rd({host_port_pkg::SEL_DATA0, 2'(k)});
      check("byte lane", lane_exp(w, 1'b0, 1'b1, 2'(k)), d & 16'h00FF);
      check("count restart", t0 + (k == 3), n_rd);
    end
    check("writes back", 1, writes_enabled);
    // change-on-read event flag with an event during the hold
    byte_mode = 1'b0;
    index_reg0 = host_port_pkg::EVENT_REG_INDEX;
    @(negedge clock) hw_event = 1'b1;
    @(negedge clock) hw_event = 1'b0;
    @(negedge clock);
    check("event set", 1, event_status);
    fork
      rd({host_port_pkg::SEL_DATA0, 2'h0});
      begin
        repeat (5) @(negedge clock);
        hw_event = 1'b1;
        @(negedge clock) hw_event = 1'b0;
      end
    join
    check("event bit", 1, d[0]);
    rd({host_port_pkg::SEL_DATA0, 2'h2});
    check("event deferred", 1, event_status);
    rd({host_port_pkg::SEL_DATA0, 2'h2});
    rd({host_port_pkg::SEL_DATA0, 2'h0});
    check("event cleared", 0, event_status);
    complete_run();
  end
endmodule
`default_nettype wire
